// ==== pkg/tcc_pkg.sv ====
// Purpose: Shared constants and types for the timer capture/compare select block.
// Assumes: One 100 MHz clock; the register port uses 8-bit indices.
// Notes: Register indices and flag positions are fixed here once.
`default_nettype none
package tcc_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 6;
  localparam int NUM_UNITS = 8;
  // Register indices on the plain register port.
  localparam logic [7:0] IDX_IO_CH5 = 8'h00;
  localparam logic [7:0] IDX_IO_HIGH_CH6 = 8'h01;
  localparam logic [7:0] IDX_IO_LOW_CH6 = 8'h02;
  localparam logic [7:0] IDX_IO_CH7 = 8'h03;
  localparam logic [7:0] IDX_IO_CH8 = 8'h04;
  localparam logic [7:0] IDX_IO_HIGH_CH9 = 8'h05;
  localparam logic [7:0] IDX_IO_LOW_CH9 = 8'h06;
  localparam logic [7:0] IDX_IO_CH10 = 8'h07;
  localparam logic [7:0] IDX_MODE = 8'h08;
  localparam logic [7:0] IDX_FLAGS = 8'h09;
  localparam logic [7:0] IDX_GR_BASE = 8'h10;
  localparam logic [7:0] IDX_GR_LAST = 8'h1F;
  // Mode register fields.
  localparam int MODE_BUF_CH6_BIT = 0;
  localparam int MODE_BUF_CH9_BIT = 1;
  localparam logic [7:0] IO_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [CNT_W-1:0] GR_RESET = 16'hFFFF;
  localparam logic [2:0] PRESCALE_UNDIVIDED = 3'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Select field bit positions.
  localparam int SEL_CAPTURE_BIT = 3;
  localparam int SEL_ALT_BIT = 2;
  localparam int SEL_BOTH_BIT = 1;

  // Alt-source wiring and select field of one capture/compare unit.
  typedef struct packed {
    logic has_alt;
    logic [3:0] sel;
  } tcc_unit_cfg_s;

  typedef struct packed {
    logic capture;
    logic match;
  } tcc_event_s;
endpackage
`default_nettype wire

// ==== src/tcc_unit.sv ====
// Purpose: One general register with its compare output or capture input logic.
// Assumes: Pin input is already synchronised; alternative source is a one-cycle pulse.
// Notes: Held inactive while disabled by buffer operation.
`default_nettype none
module tcc_unit #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk, // Clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire tcc_pkg::tcc_unit_cfg_s cfg, // Select field and alt-source flag.
  input wire logic disabled, // Register is a buffer.
  input wire logic sel_written, // Select field was just written.
  input wire logic [CNT_W-1:0] count, // Running counter value.
  input wire logic pin_sync, // Synchronised pin level.
  input wire logic alt_pulse, // Alternative capture source event.
  input wire logic gr_wr, // Software write of the general register.
  input wire logic [CNT_W-1:0] gr_wdata, // Value to write.
  output logic [CNT_W-1:0] gr_value, // General register.
  output tcc_pkg::tcc_event_s evt, // Capture or match this cycle.
  output logic pin_out, // Compare output level.
  output logic pin_oe_b // Output enable, low while driving.
);
  logic pin_prev;
  logic is_cap;
  logic out_en;
  logic rise;
  logic fall;
  logic pin_event;
  logic use_alt;

  assign is_cap = cfg.sel[tcc_pkg::SEL_CAPTURE_BIT] && !disabled;
  assign out_en = !cfg.sel[tcc_pkg::SEL_CAPTURE_BIT] && (cfg.sel[1:0] != 2'h0) && !disabled;
  assign rise = pin_sync && !pin_prev;
  assign fall = !pin_sync && pin_prev;
  // Bit 2 picks the alternative source only where one is wired.
  assign use_alt = cfg.has_alt && cfg.sel[tcc_pkg::SEL_ALT_BIT];

  // Edge selection: bit 1 means both edges, else bit 0 picks falling.
  always_comb begin
    if (cfg.sel[tcc_pkg::SEL_BOTH_BIT]) begin
      pin_event = rise || fall;
    end else if (cfg.sel[0]) begin
      pin_event = fall;
    end else begin
      pin_event = rise;
    end
  end

  assign evt.capture = is_cap && (use_alt ? alt_pulse : pin_event);
  assign evt.match = !cfg.sel[tcc_pkg::SEL_CAPTURE_BIT] && !disabled && (count == gr_value);

  // Previous pin level for edge detection on the synchronised signal.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_prev <= 1'b0;
    end else if (clk_en) begin
      pin_prev <= pin_sync;
    end
  end

  // A capture overrides a software write in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gr_value <= tcc_pkg::GR_RESET;
    end else if (clk_en) begin
      if (evt.capture) begin
        gr_value <= count;
      end else if (gr_wr) begin
        gr_value <= gr_wdata;
      end
    end
  end

  // Output level: initial level on a select write, then match actions.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
    end else if (clk_en) begin
      if (sel_written) begin
        pin_out <= cfg.sel[tcc_pkg::SEL_ALT_BIT];
      end else if (out_en && evt.match) begin
        unique case (cfg.sel[1:0])
          2'h1: pin_out <= 1'b0;
          2'h2: pin_out <= 1'b1;
          2'h3: pin_out <= !pin_out;
          default: pin_out <= pin_out;
        endcase
      end
    end
  end

  assign pin_oe_b = !out_en;
endmodule
`default_nettype wire

// ==== src/tcc_top.sv ====
// Purpose: I/O select, capture and compare for channels 5 to 10 of a 16-bit timer.
// Assumes: Counters and prescalers live outside; their values arrive as ports.
// Notes: Eight units: A of ch5..ch10, C of ch6 and ch9.
`default_nettype none
// Overview of operation
// - Compare mode with low bits 00 disables the pin output.
// - Compare mode, output on, bit 2 clear: initial pin level low.
// - Compare mode, output on, bit 2 set: initial pin level high.
// - Low bits 01 drive the pin low at compare match.
// - Low bits 10 drive the pin high at compare match.
// - Low bits 11 toggle the pin at compare match.
// - Capture from pin with low bits 00 triggers on rising edge.
// - Capture from pin with low bits 01 triggers on falling edge.
// - Capture from pin with bit 1 set triggers on both edges.
// - Channels 5 and 8 ignore bit 2 and capture from pin A.
// - Channel 6 A with 11XX captures on each channel 7 count.
// - Channel 9 A and C with 11XX capture on each channel 10 count.
// - Neighbour count capture never fires when its prescaler select is 000.
// - Channel 7 A with 11XX captures on channel 6 A match or capture.
// - Channel 10 A with 11XX captures on channel 9 A match or capture.
// - Buffer mode on channel 6 or 9 disables register C capture and compare.
// - Register C of channels 6 and 9 with 10XX captures from pin C.
// - Channels 6, 7, 9, 10 with 10XX capture from pin A.
// - Each capture copies the counter into the register and sets its flag.
// - In compare mode a counter match sets the register's flag.
module tcc_top #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk, // 100 MHz clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic [7:0] reg_addr, // Register index.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire logic [5*CNT_W-1:0] count_in, // Counters of ch5..ch9, order: 5,6,7,8,9 low first.
  input wire logic [CNT_W-1:0] count_ch10, // Counter of channel 10.
  input wire logic ch7_count_tick, // Channel 7 counted up or down.
  input wire logic ch10_count_tick, // Channel 10 counted up or down.
  input wire logic [2:0] ch7_prescale, // Channel 7 prescaler select.
  input wire logic [2:0] ch10_prescale, // Channel 10 prescaler select.
  input wire logic [7:0] pin_in, // Pin levels: A5,A6,C6,A7,A8,A9,C9,A10.
  output logic [7:0] pin_out, // Compare output levels, same order.
  output logic [7:0] pin_oe_b, // Output enables, low while driving.
  output logic [7:0] cc_flag // Capture/compare flags, same order.
);
  localparam int N = tcc_pkg::NUM_UNITS;
  logic [7:0] io_ctrl [0:N-1];
  logic [7:0] mode;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] alt_pulse;
  logic [N-1:0] disabled;
  logic [N-1:0] sel_written;
  logic [N-1:0] unit_hit;
  logic [CNT_W-1:0] gr_value [0:N-1];
  logic [CNT_W-1:0] unit_count [0:N-1];
  tcc_pkg::tcc_event_s evt [0:N-1];
  logic ch7_tick_ok;
  logic ch10_tick_ok;
  logic [15:0] next_rdata;

  // Maps a register index to the unit whose select field it holds.
  function automatic logic [3:0] unit_of(input logic [7:0] idx);
    return (idx <= tcc_pkg::IDX_IO_CH10) ? {1'b0, idx[2:0]} : 4'h8;
  endfunction

  // Two flip-flops per pin; only the second stage is read by the units.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else if (clk_en) begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // Select registers; each write also marks its unit to load the initial level.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) begin
        io_ctrl[i] <= tcc_pkg::IO_CTRL_RESET;
      end
      sel_written <= 8'h00;
    end else if (clk_en) begin
      sel_written <= 8'h00;
      if (reg_wr && unit_of(reg_addr) < 4'h8) begin
        io_ctrl[reg_addr[2:0]] <= {4'h0, reg_wdata[3:0]};
        sel_written[reg_addr[2:0]] <= 1'b1;
      end
    end
  end

  // Buffer-operation bits for register C of channels 6 and 9.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mode <= tcc_pkg::MODE_RESET;
    end else if (clk_en && reg_wr && reg_addr == tcc_pkg::IDX_MODE) begin
      mode <= {6'h00, reg_wdata[1:0]};
    end
  end

  assign disabled = {1'b0, mode[tcc_pkg::MODE_BUF_CH9_BIT], 3'h0,
                     mode[tcc_pkg::MODE_BUF_CH6_BIT], 2'h0};

  // Undivided neighbour clocks give no capture at all.
  assign ch7_tick_ok = ch7_count_tick && (ch7_prescale != tcc_pkg::PRESCALE_UNDIVIDED);
  assign ch10_tick_ok = ch10_count_tick && (ch10_prescale != tcc_pkg::PRESCALE_UNDIVIDED);

  // Alternative sources per unit; ch5 and ch8 have none.
  assign alt_pulse[0] = 1'b0;
  assign alt_pulse[1] = ch7_tick_ok;
  assign alt_pulse[2] = ch7_tick_ok;
  assign alt_pulse[3] = evt[1].capture || evt[1].match;
  assign alt_pulse[4] = 1'b0;
  assign alt_pulse[5] = ch10_tick_ok;
  assign alt_pulse[6] = ch10_tick_ok;
  assign alt_pulse[7] = evt[5].capture || evt[5].match;

  // Counter routing: units of one channel share its counter.
  assign unit_count[0] = count_in[0*CNT_W +: CNT_W];
  assign unit_count[1] = count_in[1*CNT_W +: CNT_W];
  assign unit_count[2] = count_in[1*CNT_W +: CNT_W];
  assign unit_count[3] = count_in[2*CNT_W +: CNT_W];
  assign unit_count[4] = count_in[3*CNT_W +: CNT_W];
  assign unit_count[5] = count_in[4*CNT_W +: CNT_W];
  assign unit_count[6] = count_in[4*CNT_W +: CNT_W];
  assign unit_count[7] = count_ch10;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_unit
      tcc_unit #(.CNT_W(CNT_W)) u_unit (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cfg(tcc_pkg::tcc_unit_cfg_s'{has_alt: (g != 0 && g != 4), sel: io_ctrl[g][3:0]}),
        .disabled(disabled[g]),
        .sel_written(sel_written[g]),
        .count(unit_count[g]),
        .pin_sync(sync2[g]),
        .alt_pulse(alt_pulse[g]),
        .gr_wr(clk_en && reg_wr && reg_addr == (tcc_pkg::IDX_GR_BASE + 8'(g))),
        .gr_wdata(reg_wdata[CNT_W-1:0]),
        .gr_value(gr_value[g]),
        .evt(evt[g]),
        .pin_out(pin_out[g]),
        .pin_oe_b(pin_oe_b[g])
      );
      assign unit_hit[g] = evt[g].capture || evt[g].match;
    end
  endgenerate

  // Flags set on capture or match; writing 0 clears, but a set in that cycle wins.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cc_flag <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == tcc_pkg::IDX_FLAGS) begin
        cc_flag <= (cc_flag & reg_wdata[7:0]) | unit_hit;
      end else begin
        cc_flag <= cc_flag | unit_hit;
      end
    end
  end

  // Read mux; unmapped indices return zero.
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr <= tcc_pkg::IDX_IO_CH10) begin
      next_rdata = {8'h00, io_ctrl[reg_addr[2:0]]};
    end else if (reg_addr == tcc_pkg::IDX_MODE) begin
      next_rdata = {8'h00, mode};
    end else if (reg_addr == tcc_pkg::IDX_FLAGS) begin
      next_rdata = {8'h00, cc_flag};
    end else if (reg_addr >= tcc_pkg::IDX_GR_BASE && reg_addr <= tcc_pkg::IDX_GR_BASE + 8'h07) begin
      next_rdata = 16'(gr_value[reg_addr[2:0]]);
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ==== test/tcc_checker.sv ====
// Purpose: Port-level checks of the capture/compare select block.
// Assumes: One clock domain; sees only the top ports.
// Notes: Channel 5's select field is shadowed to judge its pin edges.
`default_nettype none
module tcc_checker (
  input wire logic sys_clk, // Clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic clk_en, // Freeze control.
  input wire logic [7:0] reg_addr, // Register index.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic [7:0] pin_in, // Pin levels.
  input wire logic [7:0] pin_out, // Compare output levels.
  input wire logic [7:0] pin_oe_b, // Output enables, low while driving.
  input wire logic [7:0] cc_flag // Capture/compare flags.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic wr5;
  logic wrf;
  logic [3:0] sel5;
  // Decoded write strobes, only counted when the block is not frozen.
  assign wr5 = clk_en && reg_wr && reg_addr == tcc_pkg::IDX_IO_CH5;
  assign wrf = clk_en && reg_wr && reg_addr == tcc_pkg::IDX_FLAGS;
  // Shadow select field; needed because edge choice is not visible at the pins.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) sel5 <= 4'h0;
    else if (wr5) sel5 <= reg_wdata[3:0];
  end
  chk_out_off: assert property (wr5 && !reg_wdata[3] && reg_wdata[1:0] == 2'b00 |=> pin_oe_b[0])
    else $error("Disabled compare output still driven.");
  chk_out_init: assert property (wr5 && !reg_wdata[3] && reg_wdata[1:0] != 2'b00
    |=> !pin_oe_b[0] ##1 pin_out[0] == $past(reg_wdata[2], 2)) else $error("Initial level wrong.");
  chk_oe_steady: assert property (!(clk_en && reg_wr) |=> $stable(pin_oe_b))
    else $error("Output enable moved without a write.");
  chk_flag_sticky: assert property (!wrf |=> (cc_flag & $past(cc_flag)) == $past(cc_flag))
    else $error("Flag dropped without a clear.");
  chk_frozen_state: assert property (!clk_en |=> $stable(pin_out) && $stable(cc_flag))
    else $error("State moved while frozen.");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data outside its cycle.");
  chk_rd_flags: assert property (clk_en && reg_rd && reg_addr == tcc_pkg::IDX_FLAGS
    |=> reg_rdata[7:0] == $past(cc_flag)) else $error("Flag read differs.");
  chk_cap_edge: assert property (clk_en && sel5[3] &&
    (sel5[1] ? $changed(pin_in[0]) : (sel5[0] ? $fell(pin_in[0]) : $rose(pin_in[0])))
    |-> ##[1:4] cc_flag[0]) else $error("Capture edge left no flag.");
endmodule
bind tcc_top tcc_checker i_tcc_checker (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_b(pin_oe_b), .cc_flag(cc_flag));
`default_nettype wire

// ==== test/tcc_pin_model.sv ====
// Purpose: Far-side pin model resolving each timer pin's wire level.
// Assumes: A pin the block drives shows the block's level.
// Notes: The bench sets the outside level through lvl.
`default_nettype none
module tcc_pin_model (
  input wire logic [7:0] lvl, // Outside level per pin.
  input wire logic [7:0] pin_out, // Block output levels.
  input wire logic [7:0] pin_oe_b, // Block enables, low while driving.
  output logic [7:0] pin_in // Resolved wire levels.
);
  // A driven pin follows the block, otherwise the outside level holds.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe_b[i] ? lvl[i] : pin_out[i];
    end
  end
endmodule
`default_nettype wire

// ==== test/tcc_top_tb_top.sv ====
// Purpose: Self-checking bench for the capture/compare select block.
// Assumes: Counters, ticks and prescaler selects come from the bench.
// Notes: An integer register model gives the expected general register values.
`default_nettype none
module tcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, t7 = 1'b0, t10 = 1'b0;
  logic [7:0] reg_addr = 8'h00, lvl = 8'h00, pin_in, pin_out, pin_oe_b, cc_flag;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, count_ch10 = 16'h0000, gv;
  logic [79:0] count_in = 80'h0;
  logic [2:0] pre = 3'h1;
  int seed = 38652, error_cnt = 0, checked = 0, cycles = 0, u;
  int m_gr[8] = '{default: 32'hFFFF};
  tcc_top i_tcc_top (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_in(count_in),
    .count_ch10(count_ch10), .ch7_count_tick(t7), .ch10_count_tick(t10), .ch7_prescale(pre),
    .ch10_prescale(pre), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .cc_flag(cc_flag));
  tcc_pin_model i_tcc_pin_model (.lvl(lvl), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pin_in(pin_in));
  always #5 sys_clk = ~sys_clk;
  task automatic close_out();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(nm, e, reg_rdata);
  endtask
  // A hang is cut short far beyond the expected run length.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    clk_en <= 1'b0;
    cyc(3);
    clk_en <= 1'b1;
    cmp("oe_rst", 16'h00FF, {8'h00, pin_oe_b});
    for (int a = 0; a < 18; a++) rd(8'(a < 10 ? a : a + 6), a < 10 ? 16'h0000 : 16'hFFFF, "rst");
    rd(8'h30, 16'h0000, "unmapped");
    // Compare on channel 5 for every output code, then one match cycle.
    for (int c = 0; c < 8; c++) begin
      gv = 16'($random(seed)) | 16'h0001;
      m_gr[0] = gv;
      wr(tcc_pkg::IDX_GR_BASE, gv);
      wr(tcc_pkg::IDX_IO_CH5, 16'(c));
      cmp("oe5", 16'(c[1:0] == 2'b00), 16'(pin_oe_b[0]));
      // The initial level is loaded one edge after the select register itself.
      cyc(1);
      if (c[1:0] != 0) cmp("init5", 16'(c[2]), 16'(pin_out[0]));
      @(posedge sys_clk);
      count_in[15:0] <= gv;
      @(posedge sys_clk);
      count_in[15:0] <= 16'h0000;
      #1;
      if (c[1:0] != 0) cmp("match5", 16'(c[1:0] == 3 ? !c[2] : c[1]), 16'(pin_out[0]));
      cmp("flag5", 16'h0001, 16'(cc_flag[0]));
      wr(tcc_pkg::IDX_FLAGS, 16'h0000);
    end
    // Pin capture on channel 5: a rising then a falling edge per code.
    for (int c = 8; c < 16; c++) begin
      wr(tcc_pkg::IDX_IO_CH5, 16'(c));
      for (int e = 0; e < 2; e++) begin
        @(posedge sys_clk);
        gv = 16'($random(seed));
        count_in[15:0] <= gv;
        lvl[0] <= ~lvl[0];
        cyc(5);
        if (c[1] || c[0] != lvl[0]) m_gr[0] = gv;
        cmp("cap5", 16'(c[1] || c[0] != lvl[0]), 16'(cc_flag[0]));
        rd(tcc_pkg::IDX_GR_BASE, 16'(m_gr[0]), "gr5");
        wr(tcc_pkg::IDX_FLAGS, 16'h0000);
      end
    end
    // Neighbour chains; the last two passes run the neighbour undivided, which must not capture.
    for (int k = 0; k < 4; k++) begin
      u = k[0] ? 5 : 1;
      wr(8'(u), 16'h000C);
      wr(8'(u + 2), 16'h000C);
      @(posedge sys_clk);
      count_in <= 80'({$random(seed), $random(seed), $random(seed)});
      count_ch10 <= 16'($random(seed));
      pre <= k[1] ? 3'h0 : 3'h1;
      @(posedge sys_clk);
      t7 <= !k[0];
      t10 <= k[0];
      @(posedge sys_clk);
      t7 <= 1'b0;
      t10 <= 1'b0;
      cyc(6);
      if (!k[1]) m_gr[u] = k[0] ? count_in[79:64] : count_in[31:16];
      if (!k[1]) m_gr[u + 2] = k[0] ? count_ch10 : count_in[47:32];
      cmp("nbr_flags", {14'h0, !k[1], !k[1]}, {14'h0, cc_flag[u], cc_flag[u + 2]});
      rd(8'(16 + u), 16'(m_gr[u]), "nbr_gr_a");
      rd(8'(18 + u), 16'(m_gr[u + 2]), "nbr_gr_b");
      wr(tcc_pkg::IDX_FLAGS, 16'h0000);
    end
    // Buffer mode on channel 6 silences register C despite an output code.
    wr(tcc_pkg::IDX_MODE, 16'h0001);
    wr(tcc_pkg::IDX_IO_LOW_CH6, 16'h0005);
    cmp("oe6c_buf", 16'h0001, 16'(pin_oe_b[2]));
    wr(tcc_pkg::IDX_MODE, 16'h0000);
    cmp("oe6c", 16'h0000, 16'(pin_oe_b[2]));
    // Pin C of channel 6 on both edges: held off in buffer mode, then captures its own counter.
    for (int b = 1; b >= 0; b--) begin
      wr(tcc_pkg::IDX_MODE, 16'(b));
      wr(tcc_pkg::IDX_IO_LOW_CH6, 16'h000A);
      @(posedge sys_clk);
      gv = 16'($random(seed));
      count_in[31:16] <= gv;
      lvl[2] <= ~lvl[2];
      cyc(5);
      if (b == 0) m_gr[2] = gv;
      cmp("cap6c", 16'(b == 0), 16'(cc_flag[2]));
      rd(tcc_pkg::IDX_GR_BASE + 8'h02, 16'(m_gr[2]), "gr6c");
    end
    close_out();
  end
endmodule
`default_nettype wire
